// >>> common/pmda_params.svh
// Register offsets, field positions and reset values of the diagnostic flags and alert block
`ifndef PMDA_PARAMS_SVH
`define PMDA_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define PMDA_ADDR_W 6
`define PMDA_DIAG_ADDR 6'h0B
`define PMDA_DIAG_RESET 16'h0001

// ----------------------------------------------------------------
// Field positions of the diagnostic register
// ----------------------------------------------------------------
`define PMDA_BIT_HOLD 15
`define PMDA_BIT_ROUTE 14
`define PMDA_BIT_AVGSEL 13
`define PMDA_BIT_LEVEL 12
`define PMDA_BIT_ENERGY 11
`define PMDA_BIT_CHARGE 10
`define PMDA_BIT_MATH 9
`define PMDA_BIT_RSVD 8
`define PMDA_BIT_LIM_HI 7
`define PMDA_BIT_LIM_LO 2
`define PMDA_BIT_CONV 1
`define PMDA_BIT_TRIM 0

// ----------------------------------------------------------------
// Datapath scaling
// ----------------------------------------------------------------
`define PMDA_POWER_LIMIT_SHIFT 8
`define PMDA_AVG_NONE 3'h0

`endif

// >>> common/pmda_pkg.sv
// Types shared by the diagnostic flags and alert block
package pmda_pkg;

  // ----------------------------------------------------------------
  // Register word and alert behaviour
  // ----------------------------------------------------------------
  typedef logic [15:0] pmda_word_t;

  // Alert pin follows the fault, or holds it until the register is read
  typedef enum logic {
    PMDA_TRANSPARENT,
    PMDA_LATCHED
  } pmda_alert_mode_t;

endpackage

// >>> core/pmda_diag_alert.sv
// Diagnostic flags register and open-drain alert pin of the power monitor
`include "pmda_params.svh"

module pmda_diag_alert (
  input wire logic i_core_clk,                    // Device clock, 250 MHz
  input wire logic i_rst_b,                       // Power-up reset, active low
  // Register port from the serial bus slave
  input wire logic [`PMDA_ADDR_W-1:0] i_reg_addr, // Register address
  input wire logic i_reg_wr,                      // Write strobe, one cycle
  input wire logic [15:0] i_reg_wdata,            // Write data
  input wire logic i_reg_rd,                      // Read strobe, one cycle
  output logic [15:0] o_reg_rdata,                // Read data, registered
  output logic o_reg_rvalid,                      // Read data valid pulse
  // Measurement events
  input wire logic [2:0] i_averaging_count,       // Averaging setting
  input wire logic i_raw_valid,                   // Raw sample strobe
  input wire logic [11:0] i_raw_temp,             // Raw die temperature
  input wire logic [15:0] i_raw_current,          // Raw current
  input wire logic [14:0] i_raw_vbus,             // Raw bus voltage
  input wire logic [23:0] i_raw_power,            // Raw power
  input wire logic i_avg_valid,                   // Averaged result strobe
  input wire logic [11:0] i_avg_temp,             // Averaged die temperature
  input wire logic [15:0] i_avg_current,          // Averaged current
  input wire logic [14:0] i_avg_vbus,             // Averaged bus voltage
  input wire logic [23:0] i_avg_power,            // Averaged power
  // Thresholds from the limit registers
  input wire logic [11:0] i_temp_limit,           // Temperature over-limit
  input wire logic [15:0] i_current_high_limit,   // Current over-limit
  input wire logic [15:0] i_current_low_limit,    // Current under-limit
  input wire logic [14:0] i_vbus_high_limit,      // Bus over-limit
  input wire logic [14:0] i_vbus_low_limit,       // Bus under-limit
  input wire logic [15:0] i_power_limit,          // Power limit, 256 power LSB
  // Datapath status events
  input wire logic i_conv_start,                  // New triggered conversion
  input wire logic i_conv_done,                   // Conversion cycle complete
  input wire logic i_math_overflow,               // Calculation overflowed
  input wire logic i_energy_overflow,             // Energy accumulator wrapped
  input wire logic i_charge_overflow,             // Charge accumulator wrapped
  input wire logic i_accumulator_clear,           // Accumulator clear control
  input wire logic i_trim_checksum_err,           // Trim memory checksum error
  // Alert pin, open drain
  output logic o_alert_o,                         // Pin output value, always low
  output logic o_alert_oe_b,                      // Low while pulling the pin
  output logic o_alert_active                     // Alert state, registered
);

  // ----------------------------------------------------------------
  // Reset
  // ----------------------------------------------------------------
  logic rst_sync_b; // Released reset used by all logic below

  pmda_rst_sync u_rst_sync (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .o_rst_sync_b(rst_sync_b)
  );

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  logic diag_sel; // Address hits the diagnostic register
  logic diag_wr;  // Write to the diagnostic register
  logic diag_rd;  // Read of the diagnostic register

  always_comb begin
    diag_sel = (i_reg_addr == `PMDA_DIAG_ADDR);
    diag_wr = i_reg_wr && diag_sel;
    diag_rd = i_reg_rd && diag_sel;
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  pmda_pkg::pmda_alert_mode_t hold_reg, hold_next; // Alert hold mode
  logic route_reg, route_next;                     // Conversion-ready routing
  logic avgsel_reg, avgsel_next;                   // Averaged compare select
  logic level_reg, level_next;                     // Alert active level

  // Only the four control bits take write data; flag bits ignore writes
  always_comb begin
    hold_next = hold_reg;
    route_next = route_reg;
    avgsel_next = avgsel_reg;
    level_next = level_reg;
    if (diag_wr) begin
      hold_next = pmda_pkg::pmda_alert_mode_t'(i_reg_wdata[`PMDA_BIT_HOLD]);
      route_next = i_reg_wdata[`PMDA_BIT_ROUTE];
      avgsel_next = i_reg_wdata[`PMDA_BIT_AVGSEL];
      level_next = i_reg_wdata[`PMDA_BIT_LEVEL];
    end
  end

  // Control register state
  always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      hold_reg <= pmda_pkg::PMDA_TRANSPARENT;
      route_reg <= 1'b0;
      avgsel_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      route_reg <= route_next;
      avgsel_reg <= avgsel_next;
      level_reg <= level_next;
    end
  end

  // ----------------------------------------------------------------
  // Compare source capture
  // ----------------------------------------------------------------
  logic take_avg;                    // Compare on averaged results
  logic cmp_take;                    // Capture strobe for compare values
  logic cap_valid_reg, cap_valid_next; // At least one value captured
  logic [11:0] cap_temp_reg, cap_temp_next;
  logic [15:0] cap_current_reg, cap_current_next;
  logic [14:0] cap_vbus_reg, cap_vbus_next;
  logic [23:0] cap_power_reg, cap_power_next;

  // With no averaging the raw sample is the result, so raw is used;
  // with averaging and averaged compare selected, averaged values only land once averaging is complete
  always_comb begin
    take_avg = avgsel_reg && (i_averaging_count != `PMDA_AVG_NONE);
    cmp_take = take_avg ? i_avg_valid : i_raw_valid;
    cap_valid_next = cap_valid_reg || cmp_take;
    cap_temp_next = cap_temp_reg;
    cap_current_next = cap_current_reg;
    cap_vbus_next = cap_vbus_reg;
    cap_power_next = cap_power_reg;
    if (cmp_take) begin
      cap_temp_next = take_avg ? i_avg_temp : i_raw_temp;
      cap_current_next = take_avg ? i_avg_current : i_raw_current;
      cap_vbus_next = take_avg ? i_avg_vbus : i_raw_vbus;
      cap_power_next = take_avg ? i_avg_power : i_raw_power;
    end
  end

  // Captured compare values
  always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cap_valid_reg <= 1'b0;
      cap_temp_reg <= 12'h000;
      cap_current_reg <= 16'h0000;
      cap_vbus_reg <= 15'h0000;
      cap_power_reg <= 24'h000000;
    end else begin
      cap_valid_reg <= cap_valid_next;
      cap_temp_reg <= cap_temp_next;
      cap_current_reg <= cap_current_next;
      cap_vbus_reg <= cap_vbus_next;
      cap_power_reg <= cap_power_next;
    end
  end

  // ----------------------------------------------------------------
  // Limit comparators
  // ----------------------------------------------------------------
  logic [5:0] raw_hit; // {temp, cur hi, cur lo, vbus hi, vbus lo, power}
  logic [5:0] lim_hit; // Hits, ignored before the first capture
  logic [23:0] power_limit_wide; // Power limit scaled to power LSB

  assign power_limit_wide = {i_power_limit, {`PMDA_POWER_LIMIT_SHIFT{1'b0}}};

  pmda_limit_cmp #(.WIDTH(12), .IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_cmp_temp (
    .i_value(cap_temp_reg), .i_limit(i_temp_limit), .o_hit(raw_hit[5]));
  pmda_limit_cmp #(.WIDTH(16), .IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_cmp_cur_hi (
    .i_value(cap_current_reg), .i_limit(i_current_high_limit), .o_hit(raw_hit[4]));
  pmda_limit_cmp #(.WIDTH(16), .IS_SIGNED(1'b1), .IS_OVER(1'b0)) u_cmp_cur_lo (
    .i_value(cap_current_reg), .i_limit(i_current_low_limit), .o_hit(raw_hit[3]));
  pmda_limit_cmp #(.WIDTH(15), .IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_cmp_vbus_hi (
    .i_value(cap_vbus_reg), .i_limit(i_vbus_high_limit), .o_hit(raw_hit[2]));
  pmda_limit_cmp #(.WIDTH(15), .IS_SIGNED(1'b0), .IS_OVER(1'b0)) u_cmp_vbus_lo (
    .i_value(cap_vbus_reg), .i_limit(i_vbus_low_limit), .o_hit(raw_hit[1]));
  pmda_limit_cmp #(.WIDTH(24), .IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_cmp_power (
    .i_value(cap_power_reg), .i_limit(power_limit_wide), .o_hit(raw_hit[0]));

  // Reset values must not trip an under-limit before any measurement
  assign lim_hit = cap_valid_reg ? raw_hit : 6'h00;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic [5:0] lim_flags_reg, lim_flags_next; // Limit flags, bits 7..2
  logic conv_reg, conv_next;                 // Conversion-done flag
  logic math_reg, math_next;                 // Arithmetic overflow flag
  logic energy_reg, energy_next;             // Energy overflow flag
  logic charge_reg, charge_next;             // Charge overflow flag
  logic trim_ok_reg, trim_ok_next;           // Trim checksum status
  logic latched;                             // Hold mode in effect
  logic rd_clear;                            // Read clears held flags

  // Every set term is ORed in after the clear so an event never gets lost
  always_comb begin
    latched = (hold_reg == pmda_pkg::PMDA_LATCHED);
    rd_clear = latched && diag_rd;
    if (latched) begin
      lim_flags_next = (lim_flags_reg & ~{6{rd_clear}}) | lim_hit;
    end else begin
      lim_flags_next = lim_hit;
    end
    conv_next = (conv_reg && !i_conv_start && !rd_clear) || i_conv_done;
    math_next = (math_reg && !i_conv_start && !i_accumulator_clear) || i_math_overflow;
    energy_next = (energy_reg && !i_accumulator_clear) || i_energy_overflow;
    charge_next = (charge_reg && !i_accumulator_clear) || i_charge_overflow;
    trim_ok_next = trim_ok_reg && !i_trim_checksum_err;
  end

  // Flag state; checksum status comes out of reset as normal
  always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      lim_flags_reg <= 6'h00;
      conv_reg <= 1'b0;
      math_reg <= 1'b0;
      energy_reg <= 1'b0;
      charge_reg <= 1'b0;
      trim_ok_reg <= 1'b1;
    end else begin
      lim_flags_reg <= lim_flags_next;
      conv_reg <= conv_next;
      math_reg <= math_next;
      energy_reg <= energy_next;
      charge_reg <= charge_next;
      trim_ok_reg <= trim_ok_next;
    end
  end

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  logic alert_cond;                   // Alert should be asserted
  logic alert_reg, alert_next;        // Registered alert state
  logic oe_b_reg, oe_b_next;          // Registered pin enable

  // Open drain: active-high is shown by releasing the pin, so the pull-up
  // must be present; idle is then shown by pulling low
  always_comb begin
    alert_cond = (|lim_flags_reg) || (route_reg && conv_reg);
    alert_next = alert_cond;
    oe_b_next = ~(alert_cond ^ level_reg);
  end

  // Pin state, released under reset
  always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      alert_reg <= 1'b0;
      oe_b_reg <= 1'b1;
    end else begin
      alert_reg <= alert_next;
      oe_b_reg <= oe_b_next;
    end
  end

  assign o_alert_o = 1'b0;
  assign o_alert_oe_b = oe_b_reg;
  assign o_alert_active = alert_reg;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  pmda_pkg::pmda_word_t diag_word;   // Current register image
  pmda_pkg::pmda_word_t rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;

  // The image before the read clear is returned, so a flag is seen once
  always_comb begin
    diag_word = `PMDA_DIAG_RESET;
    diag_word[`PMDA_BIT_HOLD] = hold_reg;
    diag_word[`PMDA_BIT_ROUTE] = route_reg;
    diag_word[`PMDA_BIT_AVGSEL] = avgsel_reg;
    diag_word[`PMDA_BIT_LEVEL] = level_reg;
    diag_word[`PMDA_BIT_ENERGY] = energy_reg;
    diag_word[`PMDA_BIT_CHARGE] = charge_reg;
    diag_word[`PMDA_BIT_MATH] = math_reg;
    diag_word[`PMDA_BIT_RSVD] = 1'b0;
    diag_word[`PMDA_BIT_LIM_HI:`PMDA_BIT_LIM_LO] = lim_flags_reg;
    diag_word[`PMDA_BIT_CONV] = conv_reg;
    diag_word[`PMDA_BIT_TRIM] = trim_ok_reg;
    rvalid_next = diag_rd;
    rdata_next = diag_rd ? diag_word : 16'h0000;
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_diag_read;
    i_reg_rd && (i_reg_addr == `PMDA_DIAG_ADDR);
  endsequence

  sequence s_quiet_latched;
    latched && !diag_rd && (lim_hit == 6'h00);
  endsequence

  AST_TRANSPARENT_FOLLOW: assert property (!latched |=> lim_flags_reg == $past(lim_hit))
    else $error("limit flags do not follow the fault in transparent mode");
  AST_LATCH_HOLDS: assert property (s_quiet_latched ##0 (lim_flags_reg != 6'h00)
    |=> lim_flags_reg == $past(lim_flags_reg))
    else $error("held limit flag dropped without a read");
  AST_READ_CLEARS: assert property (s_diag_read ##0 (latched && lim_hit == 6'h00) |=> lim_flags_reg == 6'h00)
    else $error("read did not clear the held limit flags");
  AST_ROUTE_ALERT: assert property (route_reg && conv_reg |=> o_alert_active)
    else $error("routed conversion flag did not raise the alert");
  AST_NO_ROUTE: assert property (!route_reg && lim_flags_reg == 6'h00 |=> !o_alert_active)
    else $error("alert raised with no limit flag and no routing");
  AST_POLARITY: assert property (1'b1 |=> o_alert_oe_b == ($past(alert_cond) == $past(level_reg)))
    else $error("alert pin level does not match polarity");
  AST_ENERGY_STICKY: assert property (i_energy_overflow ##1 !i_accumulator_clear [*2] |-> energy_reg)
    else $error("energy overflow flag lost before a clear");
  AST_CHARGE_CLEAR: assert property (i_accumulator_clear && !i_charge_overflow |=> !charge_reg)
    else $error("charge overflow flag survived a clear");
  AST_MATH_HOLD: assert property (math_reg && !i_conv_start && !i_accumulator_clear |=> math_reg)
    else $error("arithmetic flag dropped without a trigger or clear");
  AST_RSVD_ZERO: assert property (s_diag_read |=> o_reg_rvalid && !o_reg_rdata[`PMDA_BIT_RSVD])
    else $error("reserved bit read as one");
  AST_HIT_SETS: assert property (lim_hit != 6'h00 |=> (lim_flags_reg & $past(lim_hit)) == $past(lim_hit))
    else $error("limit violation did not set its flag");
  AST_CONV_START: assert property (i_conv_start && !i_conv_done |=> !conv_reg)
    else $error("conversion flag not cleared by a new conversion");
  AST_TRIM_ERR: assert property (i_trim_checksum_err |=> !trim_ok_reg ##1 !trim_ok_reg)
    else $error("checksum status did not drop and stay low");

endmodule // pmda_diag_alert

// >>> core/pmda_limit_cmp.sv
// One limit comparator: over or under a threshold, signed or unsigned
module pmda_limit_cmp #(
  parameter int WIDTH = 16,     // Width of value and threshold
  parameter bit IS_SIGNED = 1'b1, // Two's complement compare
  parameter bit IS_OVER = 1'b1  // 1: hit above limit, 0: hit below
) (
  input wire logic [WIDTH-1:0] i_value, // Measured value
  input wire logic [WIDTH-1:0] i_limit, // Threshold
  output logic o_hit                    // Value is beyond the limit
);

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  logic above; // Strictly greater than the limit
  logic below; // Strictly less than the limit

  // Equal to the limit is not a violation in either direction
  always_comb begin
    if (IS_SIGNED) begin
      above = $signed(i_value) > $signed(i_limit);
      below = $signed(i_value) < $signed(i_limit);
    end else begin
      above = i_value > i_limit;
      below = i_value < i_limit;
    end
    o_hit = IS_OVER ? above : below;
  end

endmodule // pmda_limit_cmp

// >>> core/pmda_rst_sync.sv
// Reset release synchroniser: asynchronous assert, two-flop release
module pmda_rst_sync (
  input wire logic i_core_clk, // Device clock
  input wire logic i_rst_b,    // Raw reset, active low
  output logic o_rst_sync_b    // Released reset, active low
);

  // ----------------------------------------------------------------
  // Release chain
  // ----------------------------------------------------------------
  logic meta_reg; // First stage, read only by the second

  // Both stages take constants under reset; release ripples through
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_reg <= 1'b0;
      o_rst_sync_b <= 1'b0;
    end else begin
      meta_reg <= 1'b1;
      o_rst_sync_b <= meta_reg;
    end
  end

endmodule // pmda_rst_sync

// >>> verif/pmda_diag_alert_tb.sv
// Self-checking bench for the diagnostic flags and alert block
module pmda_diag_alert_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic clk = 1'b0; // 250 MHz core clock
  logic rst_b = 1'b0; // Reset, active low
  logic [5:0] addr = 6'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [2:0] avg_cnt = 3'h0;
  logic [11:0] temp = 12'h000;
  logic [11:0] avg_temp = 12'h000;
  logic [15:0] cur = 16'h0000;
  logic [15:0] cur_lo = 16'h8000; // Under-limit, movable for one case
  logic [14:0] vbus = 15'h0100;
  logic [23:0] power = 24'h000000;
  logic [8:0] ev = 9'h000; // Strobes: start,done,math,energy,charge,clear,trim,raw,avg
  logic [15:0] rdata;
  logic rvalid, alert_o, oe_b, pin, act;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  pmda_diag_alert dut_u (.i_core_clk(clk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_averaging_count(avg_cnt), .i_raw_valid(ev[7]), .i_raw_temp(temp), .i_raw_current(cur),
    .i_raw_vbus(vbus), .i_raw_power(power), .i_avg_valid(ev[8]), .i_avg_temp(avg_temp),
    .i_avg_current(cur), .i_avg_vbus(vbus), .i_avg_power(power), .i_temp_limit(12'h050),
    .i_current_high_limit(16'h0050), .i_current_low_limit(cur_lo), .i_vbus_high_limit(15'h7000),
    .i_vbus_low_limit(15'h0020), .i_power_limit(16'h0001), .i_conv_start(ev[0]), .i_conv_done(ev[1]),
    .i_math_overflow(ev[2]), .i_energy_overflow(ev[3]), .i_charge_overflow(ev[4]),
    .i_accumulator_clear(ev[5]), .i_trim_checksum_err(ev[6]), .o_alert_o(alert_o),
    .o_alert_oe_b(oe_b), .o_alert_active(act));
  pmda_host_model host_u (.i_alert_o(alert_o), .i_alert_oe_b(oe_b), .o_alert_pin(pin));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Read answers one cycle after the strobe, sampled mid-cycle
  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    addr = a;
    rd = 1'b1;
    @(negedge clk) rd = 1'b0;
    chk({15'h0000, rvalid}, {15'h0000, a == 6'h0B});
    chk(rdata, exp);
    // Idle cycle so a following read never re-raises the strobe it just dropped
    @(negedge clk);
  endtask
  task automatic wrc(input logic [15:0] d);
    addr = 6'h0B;
    wdata = d;
    wr = 1'b1;
    @(negedge clk) wr = 1'b0;
  endtask
  // Limit flags land two edges after the raw strobe, the pin one more; three more cycles covers both
  task automatic pulse(input logic [8:0] m);
    ev = m;
    @(negedge clk) ev = 9'h000;
    repeat (3) @(negedge clk);
  endtask
  task automatic pin_is(input logic v);
    chk({15'h0000, pin}, {15'h0000, v});
    // Alert state is active when the line shows the level last written to bit 12
    chk({15'h0000, act}, {15'h0000, v == wdata[12]});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(6'h0B, 16'h0001);
    rdc(6'h0C, 16'h0000);
    pin_is(1'b1);
  endtask
  task automatic t_latch;
    wrc(16'h8EFE);
    rdc(6'h0B, 16'h8001);
    cur = 16'h0100;
    pulse(9'h080);
    cur = 16'h0000;
    pulse(9'h080);
    pin_is(1'b0);
    rdc(6'h0B, 16'h8041);
    rdc(6'h0B, 16'h8001);
    repeat (2) @(negedge clk);
    pin_is(1'b1);
  endtask
  task automatic t_trans;
    wrc(16'h0000);
    vbus = 15'h0010;
    cur_lo = 16'h0010;
    power = 24'h000200;
    pulse(9'h080);
    pin_is(1'b0);
    rdc(6'h0B, 16'h002D);
    rdc(6'h0B, 16'h002D);
    cur_lo = 16'h8000;
    power = 24'h000000;
    pulse(9'h080);
    rdc(6'h0B, 16'h0009);
    wrc(16'h1000);
    repeat (2) @(negedge clk);
    pin_is(1'b1);
    vbus = 15'h7100;
    pulse(9'h080);
    rdc(6'h0B, 16'h1011);
    vbus = 15'h0100;
    pulse(9'h080);
    pin_is(1'b0);
  endtask
  task automatic t_route;
    wrc(16'h4000);
    pulse(9'h002);
    pin_is(1'b0);
    rdc(6'h0B, 16'h4003);
    pulse(9'h001);
    rdc(6'h0B, 16'h4001);
    pin_is(1'b1);
    wrc(16'hC000);
    pulse(9'h002);
    rdc(6'h0B, 16'hC003);
    rdc(6'h0B, 16'hC001);
  endtask
  task automatic t_avg;
    wrc(16'h2000);
    temp = 12'h100;
    pulse(9'h080);
    rdc(6'h0B, 16'h2081);
    avg_cnt = 3'h1;
    temp = 12'h000;
    pulse(9'h080);
    rdc(6'h0B, 16'h2081);
    pulse(9'h100);
    rdc(6'h0B, 16'h2001);
    avg_temp = 12'h100;
    pulse(9'h100);
    rdc(6'h0B, 16'h2081);
    avg_temp = 12'h000;
    pulse(9'h100);
    rdc(6'h0B, 16'h2001);
  endtask
  task automatic t_ovf;
    wrc(16'h0000);
    pulse(9'h01C);
    rdc(6'h0B, 16'h0E01);
    pulse(9'h001);
    rdc(6'h0B, 16'h0C01);
    pulse(9'h020);
    rdc(6'h0B, 16'h0001);
    pulse(9'h028);
    rdc(6'h0B, 16'h0801);
    pulse(9'h060);
    rdc(6'h0B, 16'h0000);
  endtask
  // Mid-run reset brings the checksum status back to normal
  task automatic t_rerun;
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rdc(6'h0B, 16'h0001);
    pin_is(1'b1);
  endtask

  task automatic end_of_test;
    $display("Mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard: the whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_latch();
    t_trans();
    t_route();
    t_avg();
    t_ovf();
    t_rerun();
    end_of_test();
  end
endmodule // pmda_diag_alert_tb

// >>> verif/pmda_host_model.sv
// Host side model: pull-up resistor on the open-drain alert line
module pmda_host_model (
  input wire logic i_alert_o,    // Pin drive value from the device
  input wire logic i_alert_oe_b, // Low while the device pulls
  output logic o_alert_pin       // Resolved line level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released line floats up, so it never keeps the last driven value
  assign o_alert_pin = i_alert_oe_b ? 1'b1 : i_alert_o;
endmodule // pmda_host_model
